// ==== uth_tx_path.sv ====
// The implementer's own choices: register access over APB and the register offsets.
module uth_tx_path #(
  parameter int DEPTH = uth_pkg::TX_DEPTH
) (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial side
  output logic serial_output,
  output logic baud_tick_output,
  // Interrupt
  output logic irq
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int NI = uth_pkg::NUM_IRQ;

  function automatic logic parity_of(input logic [7:0] d, input uth_pkg::uth_lcr_t l);
    logic [7:0] m;
    m = 8'hff >> (3 - l.wls);
    return (^(d & m)) ^ ~l.eps;
  endfunction : parity_of

  function automatic logic [CW-1:0] low_mark(input logic [1:0] trig);
    case (trig)
      2'h0: low_mark = CW'(0);
      2'h1: low_mark = CW'(8);
      2'h2: low_mark = CW'(16);
      default: low_mark = CW'(32);
    endcase
  endfunction : low_mark

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] scratch_reg;
  uth_pkg::uth_lcr_t lcr_reg;
  uth_pkg::uth_fcr_t fcr_reg;
  logic [15:0] div_reg;
  logic [NI-1:0] en_reg;
  logic [NI-1:0] stat_reg;
  logic [NI-1:0] stat_next;

  // FIFO
  logic [7:0] mem [DEPTH];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic [CW-1:0] count_reg;

  // Transmitter
  uth_pkg::uth_tx_state_t state_reg;
  logic [7:0] tx_shift_register;
  logic [5:0] tick_cnt_reg;
  logic [2:0] bit_cnt_reg;
  logic par_reg;
  logic baud_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode
  logic access;
  logic wr_done;
  logic mapped;
  logic [31:0] rd_value;
  logic char_mode;
  logic full;
  logic empty;
  logic wr_tx;
  logic push;
  logic pop;
  logic fifo_clr;
  logic div_wr;
  logic [15:0] div_in;

  // A write lands on the edge where pready is seen high, one wait state in
  assign access = psel & penable;
  assign wr_done = ce & access & pready & pwrite;
  assign char_mode = ~fcr_reg.fifo_en;
  assign empty = (count_reg == CW'(0));
  // Character mode behaves as a one-deep holding register
  assign full = char_mode ? !empty : (count_reg == CW'(DEPTH));
  assign wr_tx = wr_done & (paddr == uth_pkg::OFF_TXDATA);
  assign push = wr_tx & ~full;
  assign fifo_clr = wr_done & (paddr == uth_pkg::OFF_FCR) & pwdata[uth_pkg::FCR_CLR_BIT];
  // Loading only on a tick keeps the start bit a full sixteen ticks long
  assign pop = ce & baud_tick & (state_reg == uth_pkg::ST_IDLE) & ~empty & ~fifo_clr;
  assign div_wr = wr_done & ((paddr == uth_pkg::OFF_DIVL) | (paddr == uth_pkg::OFF_DIVH));
  // The counter keeps the stored divisor; only a divisor write shows the new byte early
  assign div_in = !div_wr ? div_reg : ((paddr == uth_pkg::OFF_DIVL)
    ? {div_reg[15:8], pwdata[7:0]} : {pwdata[7:0], div_reg[7:0]});

  always_comb begin
    mapped = 1'b1;
    rd_value = 32'h0000_0000;
    unique case (paddr)
      uth_pkg::OFF_TXDATA: rd_value = 32'h0000_0000;
      uth_pkg::OFF_LCR: rd_value[4:0] = lcr_reg;
      uth_pkg::OFF_FCR: begin
        rd_value[uth_pkg::FCR_EN_BIT] = fcr_reg.fifo_en;
        rd_value[uth_pkg::FCR_TRIG_LSB +: 2] = fcr_reg.trig;
      end
      uth_pkg::OFF_DIVL: rd_value[7:0] = div_reg[7:0];
      uth_pkg::OFF_DIVH: rd_value[7:0] = div_reg[15:8];
      uth_pkg::OFF_SCRATCH: rd_value[7:0] = scratch_reg;
      uth_pkg::OFF_IRQ_STAT: rd_value[NI-1:0] = stat_reg;
      uth_pkg::OFF_IRQ_CLR: rd_value = 32'h0000_0000;
      uth_pkg::OFF_IRQ_EN: rd_value[NI-1:0] = en_reg;
      uth_pkg::OFF_STATUS: begin
        rd_value[CW-1:0] = count_reg;
        rd_value[uth_pkg::STAT_BUSY_BIT] = (state_reg != uth_pkg::ST_IDLE);
        rd_value[uth_pkg::STAT_EMPTY_BIT] = empty;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (access && !pready) begin
        pready <= 1'b1;
        pslverr <= ~mapped;
        prdata <= pwrite ? 32'h0000_0000 : rd_value;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scratch_reg <= uth_pkg::SCRATCH_RST;
    end else if (wr_done && paddr == uth_pkg::OFF_SCRATCH) begin
      scratch_reg <= pwdata[7:0];
    end
  end

  // Width, parity enable and stop changes mid-character affect the bits still to go; the parity value is fixed at load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcr_reg <= uth_pkg::LCR_RST;
      fcr_reg <= '0;
      en_reg <= '0;
    end else if (wr_done) begin
      if (paddr == uth_pkg::OFF_LCR) begin
        lcr_reg <= uth_pkg::uth_lcr_t'(pwdata[4:0]);
      end
      if (paddr == uth_pkg::OFF_FCR) begin
        fcr_reg.fifo_en <= pwdata[uth_pkg::FCR_EN_BIT];
        fcr_reg.trig <= pwdata[uth_pkg::FCR_TRIG_LSB +: 2];
      end
      if (paddr == uth_pkg::OFF_IRQ_EN) begin
        en_reg <= pwdata[NI-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= uth_pkg::DIV_RST;
    end else if (wr_done) begin
      if (paddr == uth_pkg::OFF_DIVL) begin
        div_reg[7:0] <= pwdata[7:0];
      end
      if (paddr == uth_pkg::OFF_DIVH) begin
        div_reg[15:8] <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Baud generator
  uth_baud_gen u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .divisor(div_in),
    .reload(div_wr),
    .tick(baud_tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_tick_output <= 1'b0;
    end else if (ce) begin
      baud_tick_output <= baud_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Holding queue
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wptr_reg] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else if (fifo_clr) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= PW'(wptr_reg + 1'b1);
      end
      if (pop) begin
        rptr_reg <= PW'(rptr_reg + 1'b1);
      end
      count_reg <= CW'(count_reg + CW'(push) - CW'(pop));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit shifter
  logic [2:0] last_bit;
  logic [5:0] stop_ticks;
  logic bit_end;

  assign last_bit = 3'(lcr_reg.wls) + 3'h4;
  assign bit_end = (tick_cnt_reg == 6'(uth_pkg::TICKS_PER_BIT - 1));
  always_comb begin
    if (!lcr_reg.stb) begin
      stop_ticks = 6'(uth_pkg::TICKS_PER_BIT);
    end else if (lcr_reg.wls == 2'h0) begin
      stop_ticks = 6'(uth_pkg::TICKS_STOP_HALF);
    end else begin
      stop_ticks = 6'(uth_pkg::TICKS_STOP_TWO);
    end
  end

  // Nothing moves between baud ticks, so the bus clock never sets bit time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= uth_pkg::ST_IDLE;
      tx_shift_register <= 8'h00;
      tick_cnt_reg <= 6'h00;
      bit_cnt_reg <= 3'h0;
      par_reg <= 1'b0;
      serial_output <= 1'b1;
    end else if (ce) begin
      unique case (state_reg)
        uth_pkg::ST_IDLE: begin
          serial_output <= 1'b1;
          if (pop) begin
            tx_shift_register <= mem[rptr_reg];
            par_reg <= parity_of(mem[rptr_reg], lcr_reg);
            serial_output <= 1'b0;
            tick_cnt_reg <= 6'h00;
            bit_cnt_reg <= 3'h0;
            state_reg <= uth_pkg::ST_START;
          end
        end
        uth_pkg::ST_START: begin
          if (baud_tick) begin
            tick_cnt_reg <= bit_end ? 6'h00 : tick_cnt_reg + 6'h01;
            if (bit_end) begin
              serial_output <= tx_shift_register[0];
              state_reg <= uth_pkg::ST_DATA;
            end
          end
        end
        uth_pkg::ST_DATA: begin
          if (baud_tick) begin
            tick_cnt_reg <= bit_end ? 6'h00 : tick_cnt_reg + 6'h01;
            if (bit_end) begin
              tx_shift_register <= tx_shift_register >> 1;
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg != last_bit) begin
                serial_output <= tx_shift_register[1];
              end else if (lcr_reg.pen) begin
                serial_output <= par_reg;
                state_reg <= uth_pkg::ST_PARITY;
              end else begin
                serial_output <= 1'b1;
                state_reg <= uth_pkg::ST_STOP;
              end
            end
          end
        end
        uth_pkg::ST_PARITY: begin
          if (baud_tick) begin
            tick_cnt_reg <= bit_end ? 6'h00 : tick_cnt_reg + 6'h01;
            if (bit_end) begin
              serial_output <= 1'b1;
              state_reg <= uth_pkg::ST_STOP;
            end
          end
        end
        uth_pkg::ST_STOP: begin
          if (baud_tick) begin
            tick_cnt_reg <= tick_cnt_reg + 6'h01;
            if (tick_cnt_reg == stop_ticks - 6'h01) begin
              tick_cnt_reg <= 6'h00;
              state_reg <= uth_pkg::ST_IDLE;
            end
          end
        end
        default: state_reg <= uth_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, write-one-to-clear, set wins
  logic [NI-1:0] set_vec;
  logic [NI-1:0] clr_vec;

  always_comb begin
    set_vec = '0;
    clr_vec = '0;
    set_vec[uth_pkg::IRQ_HOLD_EMPTY] = ce & char_mode & empty & ~wr_tx;
    set_vec[uth_pkg::IRQ_FIFO_LOW] = ce & ~char_mode
      & (count_reg <= low_mark(fcr_reg.trig));
    set_vec[uth_pkg::IRQ_OVERRUN] = wr_tx & full;
    clr_vec[uth_pkg::IRQ_HOLD_EMPTY] = char_mode & wr_tx;
    if (wr_done && paddr == uth_pkg::OFF_IRQ_CLR) begin
      clr_vec = clr_vec | pwdata[NI-1:0];
    end
    stat_next = set_vec | (stat_reg & ~clr_vec);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      stat_reg <= stat_next;
      irq <= |(stat_reg & en_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_scratch_hold;
    @(posedge pclk) disable iff (!presetn)
    (wr_done && paddr == uth_pkg::OFF_SCRATCH) |=> (scratch_reg == $past(pwdata[7:0]));
  endproperty
  a_scratch_hold: assert property (p_scratch_hold)
    else $error("Scratch register lost written value");

  property p_depth;
    @(posedge pclk) disable iff (!presetn)
    count_reg <= CW'(DEPTH);
  endproperty
  a_depth: assert property (p_depth)
    else $error("Holding queue over 64 entries");

  property p_tick_only;
    @(posedge pclk) disable iff (!presetn)
    ($past(state_reg) != uth_pkg::ST_IDLE && state_reg != $past(state_reg)) |-> $past(baud_tick);
  endproperty
  a_tick_only: assert property (p_tick_only)
    else $error("Shifter advanced without a baud tick");

  property p_load_idle;
    @(posedge pclk) disable iff (!presetn)
    pop |-> (state_reg == uth_pkg::ST_IDLE) ##1 (state_reg == uth_pkg::ST_START && !serial_output);
  endproperty
  a_load_idle: assert property (p_load_idle)
    else $error("Load outside idle or no start bit");

  property p_idle_high;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == uth_pkg::ST_IDLE && $past(state_reg) == uth_pkg::ST_IDLE) |-> serial_output;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("Serial line not high while idle");

  property p_irq_char;
    @(posedge pclk) disable iff (!presetn)
    (ce && stat_reg[0] && en_reg[0]) |=> irq;
  endproperty
  a_irq_char: assert property (p_irq_char)
    else $error("Enabled empty interrupt not raised");

  property p_clear_on_write;
    @(posedge pclk) disable iff (!presetn)
    (ce && char_mode && wr_tx) |=> !stat_reg[uth_pkg::IRQ_HOLD_EMPTY];
  endproperty
  a_clear_on_write: assert property (p_clear_on_write)
    else $error("Character write did not clear empty interrupt");

  property p_bit_len;
    @(posedge pclk) disable iff (!presetn)
    (ce && baud_tick && state_reg == uth_pkg::ST_START && bit_end)
      |=> state_reg == uth_pkg::ST_DATA && tick_cnt_reg == 6'h00;
  endproperty
  a_bit_len: assert property (p_bit_len)
    else $error("Start bit not sixteen ticks");

endmodule : uth_tx_path

// ==== uth_pkg.sv ====
package uth_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on APB
  localparam logic [7:0] OFF_TXDATA = 8'h00;
  localparam logic [7:0] OFF_LCR = 8'h04;
  localparam logic [7:0] OFF_FCR = 8'h08;
  localparam logic [7:0] OFF_DIVL = 8'h0c;
  localparam logic [7:0] OFF_DIVH = 8'h10;
  localparam logic [7:0] OFF_SCRATCH = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h1c;
  localparam logic [7:0] OFF_IRQ_EN = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int LCR_WLS_LSB = 0;
  localparam int LCR_STB_BIT = 2;
  localparam int LCR_PEN_BIT = 3;
  localparam int LCR_EPS_BIT = 4;
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_CLR_BIT = 1;
  localparam int FCR_TRIG_LSB = 6;
  localparam int IRQ_HOLD_EMPTY = 0;
  localparam int IRQ_FIFO_LOW = 1;
  localparam int IRQ_OVERRUN = 2;
  localparam int NUM_IRQ = 3;
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_EMPTY_BIT = 8;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values, sizes and timing counts
  localparam logic [4:0] LCR_RST = 5'h03;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam int TX_DEPTH = 64;
  localparam int TICKS_PER_BIT = 16;
  localparam int TICKS_STOP_HALF = 24;
  localparam int TICKS_STOP_TWO = 32;

  typedef struct packed {
    logic eps;
    logic pen;
    logic stb;
    logic [1:0] wls;
  } uth_lcr_t;

  typedef struct packed {
    logic [1:0] trig;
    logic fifo_en;
  } uth_fcr_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_DATA = 3'h3,
    ST_PARITY = 3'h2,
    ST_STOP = 3'h6
  } uth_tx_state_t;

endpackage : uth_pkg

// ==== uth_baud_gen.sv ====
module uth_baud_gen (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Divisor control
  input wire logic [15:0] divisor,
  input wire logic reload,
  // Sixteen-times bit clock
  output logic tick
);

  logic [15:0] cnt_reg;

  // Reload on any divisor write so a new rate never waits out an old long count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 16'h0001;
      tick <= 1'b0;
    end else if (ce) begin
      if (reload) begin
        cnt_reg <= divisor;
        tick <= 1'b0;
      end else if (divisor == 16'h0000) begin
        // A zero divisor stops the transmitter rather than running flat out
        tick <= 1'b0;
      end else if (cnt_reg <= 16'h0001) begin
        cnt_reg <= divisor;
        tick <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg - 16'h0001;
        tick <= 1'b0;
      end
    end
  end

  property p_reload_count;
    @(posedge pclk) disable iff (!presetn)
    (ce && reload) |=> (cnt_reg == $past(divisor) && !tick);
  endproperty
  a_reload_count: assert property (p_reload_count)
    else $error("Baud counter not reloaded on divisor write");

endmodule : uth_baud_gen

// ==== uth_rx_model.sv ====
module uth_rx_model (
  // Clock and serial line
  input wire logic pclk,
  input wire logic line,
  // Frame format expected by the far end
  input wire logic [15:0] bit_cycles,
  input wire logic [3:0] nbits,
  input wire logic par_en,
  // Last character received
  output logic [7:0] rx_byte,
  output logic frame_ok,
  output int rx_count
);
  timeunit 1ns;
  timeprecision 1ps;

  //////////////////////////////////////////////////////////////////////////////
  // Samples mid-bit, so a wrong bit period shows up as corrupt data
  initial begin
    logic ok;
    logic par;
    logic [7:0] b;
    rx_byte = 8'h00;
    frame_ok = 1'b0;
    rx_count = 0;
    forever begin
      @(negedge line);
      repeat (bit_cycles / 2) @(posedge pclk);
      ok = (line === 1'b0);
      b = 8'h00;
      par = 1'b0;
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_cycles) @(posedge pclk);
        b[i] = line;
        par = par ^ line;
      end
      if (par_en) begin
        repeat (bit_cycles) @(posedge pclk);
        ok = ok && ((par ^ line) === 1'b0);
      end
      repeat (bit_cycles) @(posedge pclk);
      ok = ok && (line === 1'b1);
      rx_byte = b;
      frame_ok = ok;
      rx_count++;
    end
  end
endmodule : uth_rx_model

// ==== tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic serial_output, baud_tick_output, irq, par_en, frame_ok, err;
  logic [7:0] paddr, rx_byte;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] bit_cycles;
  logic [3:0] nbits;
  int rx_count, n_errors, n_compared, cyc;

  uth_tx_path uth_tx_path_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_output(serial_output),
    .baud_tick_output(baud_tick_output), .irq(irq)
  );

  uth_rx_model uth_rx_model_i (
    .pclk(pclk), .line(serial_output), .bit_cycles(bit_cycles), .nbits(nbits),
    .par_en(par_en), .rx_byte(rx_byte), .frame_ok(frame_ok), .rx_count(rx_count)
  );

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; the request is held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check(32'(n < 50), 32'h0000_0001);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rdchk

  task automatic wait_rx(input int n);
    cyc = 0;
    while (rx_count < n && cyc < 5000) begin
      @(posedge pclk);
      cyc++;
    end
    check(32'(rx_count), 32'(n));
  endtask : wait_rx

  task automatic end_of_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  //////////////////////////////////////////////////////////////////////////////
  // Whole sequence needs well under 10000 cycles
  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    end_of_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, err} = 5'h00;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    n_errors = 0;
    n_compared = 0;
    bit_cycles = 16'h0020;
    nbits = 4'h8;
    par_en = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'(serial_output), 32'h0000_0001);
    rdchk(uth_pkg::OFF_SCRATCH, 32'(uth_pkg::SCRATCH_RST));
    rdchk(uth_pkg::OFF_LCR, 32'(uth_pkg::LCR_RST));
    wr(uth_pkg::OFF_SCRATCH, 32'h1234_56a5);
    rdchk(uth_pkg::OFF_SCRATCH, 32'h0000_00a5);
    rdchk(uth_pkg::OFF_LCR, 32'(uth_pkg::LCR_RST));
    rdchk(uth_pkg::OFF_STATUS, 32'h0000_0100);
    rdchk(8'h3c, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    // A large high byte then zero: the second write must restart the count
    wr(uth_pkg::OFF_DIVL, 32'h0000_0002);
    wr(uth_pkg::OFF_DIVH, 32'h0000_0010);
    wr(uth_pkg::OFF_DIVH, 32'h0000_0000);
    cyc = 0;
    do begin
      @(posedge pclk);
      cyc++;
    end while (baud_tick_output !== 1'b1 && cyc < 20);
    check(32'(cyc < 8), 32'h0000_0001);
    cyc = 0;
    do begin
      @(posedge pclk);
      cyc++;
    end while (baud_tick_output !== 1'b1 && cyc < 20);
    check(32'(cyc), 32'h0000_0002);
    //////////////////////////////////////////////////////////////////////////////
    // Character mode interrupt and holding behaviour
    wr(uth_pkg::OFF_IRQ_EN, 32'h0000_0007);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h0000_0001);
    rdchk(uth_pkg::OFF_IRQ_STAT, 32'h0000_0001);
    wr(uth_pkg::OFF_TXDATA, 32'h0000_003c);
    wr(uth_pkg::OFF_TXDATA, 32'h0000_00a5);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h0000_0000);
    rdchk(uth_pkg::OFF_STATUS, 32'h0000_0081);
    wr(uth_pkg::OFF_TXDATA, 32'h0000_0077);
    rdchk(uth_pkg::OFF_IRQ_STAT, 32'h0000_0004);
    wr(uth_pkg::OFF_IRQ_CLR, 32'h0000_0004);
    rdchk(uth_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    wait_rx(1);
    check({24'h00_0000, rx_byte}, 32'h0000_003c);
    check(32'(frame_ok), 32'h0000_0001);
    cyc = 0;
    while (serial_output !== 1'b0 && cyc < 2000) begin
      @(posedge pclk);
      cyc++;
    end
    cyc = 0;
    while (serial_output === 1'b0 && cyc < 200) begin
      @(posedge pclk);
      cyc++;
    end
    check(32'(cyc), 32'(uth_pkg::TICKS_PER_BIT * 2));
    wait_rx(2);
    check({24'h00_0000, rx_byte}, 32'h0000_00a5);
    check(32'(irq), 32'h0000_0001);
    wr(uth_pkg::OFF_IRQ_EN, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h0000_0000);
    // Seven bits with even parity
    repeat (40) @(posedge pclk);
    nbits = 4'h7;
    par_en = 1'b1;
    wr(uth_pkg::OFF_LCR, 32'h0000_001a);
    wr(uth_pkg::OFF_TXDATA, 32'h0000_0035);
    wait_rx(3);
    check({24'h00_0000, rx_byte}, 32'h0000_0035);
    check(32'(frame_ok), 32'h0000_0001);
    //////////////////////////////////////////////////////////////////////////////
    // Queue mode; divisor zero stalls the shifter so the queue can fill
    repeat (40) @(posedge pclk);
    wr(uth_pkg::OFF_LCR, 32'h0000_0003);
    wr(uth_pkg::OFF_DIVL, 32'h0000_0000);
    wr(uth_pkg::OFF_FCR, 32'h0000_0001);
    for (int i = 0; i <= uth_pkg::TX_DEPTH; i++) begin
      wr(uth_pkg::OFF_TXDATA, 32'(i));
    end
    rdchk(uth_pkg::OFF_STATUS, 32'h0000_0040);
    rdchk(uth_pkg::OFF_IRQ_STAT, 32'h0000_0007);
    wr(uth_pkg::OFF_IRQ_CLR, 32'h0000_0007);
    rdchk(uth_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    wr(uth_pkg::OFF_TXDATA, 32'h0000_00ff);
    rdchk(uth_pkg::OFF_IRQ_STAT, 32'h0000_0004);
    wr(uth_pkg::OFF_FCR, 32'h0000_0003);
    rdchk(uth_pkg::OFF_STATUS, 32'h0000_0100);
    rdchk(uth_pkg::OFF_IRQ_STAT, 32'h0000_0006);
    end_of_test();
  end
endmodule : tb_top
